// file: core/est_pkg.sv
// package of constants for the excitation signal timer
package est_pkg;
  // bus register byte offsets
  localparam logic [7:0] EST_CTRL_OFS = 8'h00;
  localparam logic [7:0] EST_PERIOD_OFS = 8'h04;
  localparam logic [7:0] EST_CMP_A_OFS = 8'h08;
  localparam logic [7:0] EST_CMP_B_OFS = 8'h0C;
  localparam logic [7:0] EST_CMP_C_OFS = 8'h10;
  localparam logic [7:0] EST_COUNT_OFS = 8'h14;
  localparam logic [7:0] EST_STAT_OFS = 8'h18;
  localparam logic [7:0] EST_MASK_OFS = 8'h1C;
  localparam logic [7:0] EST_OUT_OFS = 8'h20;
  // control fields
  localparam int EST_CTRL_RUN_BIT = 0;
  localparam int EST_CTRL_VARIANT_BIT = 1;
  localparam int EST_CTRL_PRESC_LSB = 8;
  localparam int EST_CTRL_PRESC_W = 8;
  // status / mask bit positions
  localparam int EST_ST_CMP_A = 0;
  localparam int EST_ST_CMP_B = 1;
  localparam int EST_ST_CMP_C = 2;
  localparam int EST_ST_PERIOD = 3;
  localparam int EST_ST_W = 4;
  // timing, clock 100 MHz
  localparam int EST_CLK_MHZ = 100;
  localparam int EST_CYCLE_NS = 100000;
  localparam int EST_CMP_A_NS = 50000;
  localparam int EST_CMP_B_NS = 83330;
  localparam int EST_CMP_C_NS = 66670;
  localparam int EST_CNT_W = 16;
  // compare value in counts for a time, counter clears on the period match
  localparam logic [15:0] EST_PERIOD_RST = 16'(EST_CYCLE_NS * EST_CLK_MHZ / 1000 - 1);
  localparam logic [15:0] EST_CMP_A_RST = 16'(EST_CMP_A_NS * EST_CLK_MHZ / 1000);
  localparam logic [15:0] EST_CMP_B_RST = 16'(EST_CMP_B_NS * EST_CLK_MHZ / 1000);
  localparam logic [15:0] EST_CMP_C_RST = 16'(EST_CMP_C_NS * EST_CLK_MHZ / 1000);
  // saw-wave variant values at the 100 MHz count clock
  localparam logic [15:0] EST_PWM_CYCLE = 16'h2EDF;
  localparam logic [15:0] EST_PWM_CMP_A = 16'h176F;
  localparam logic [15:0] EST_PWM_CMP_B = 16'h270F;
  localparam logic [3:0] EST_IRQ_PRIORITY = 4'hB;
  localparam logic [7:0] EST_PRESC_RST = 8'h00;
  localparam logic [1:0] EST_RESP_OKAY = 2'b00;
  localparam logic [1:0] EST_RESP_SLVERR = 2'b10;
endpackage

// file: core/est_counter.sv
// period counter with three compare-match events
`timescale 1ns/1ps
`default_nettype none
module est_counter
  import est_pkg::*;
#(
  parameter int CNT_W = est_pkg::EST_CNT_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic [CNT_W-1:0] period_compare_reg,
  input wire logic [CNT_W-1:0] compare_reg_a,
  input wire logic [CNT_W-1:0] compare_reg_b,
  input wire logic [CNT_W-1:0] compare_reg_c,
  output logic [CNT_W-1:0] timer_count_value,
  output logic match_a,
  output logic match_b,
  output logic match_c,
  output logic match_period
);
  logic step;
  assign step = run && tick;
  // compares read the live registers, so a write acts on the next count
  assign match_period = step && (timer_count_value == period_compare_reg); // RULE9
  assign match_a = step && (timer_count_value == compare_reg_a);
  assign match_b = step && (timer_count_value == compare_reg_b);
  assign match_c = step && (timer_count_value == compare_reg_c);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_count_value <= '0;
    else if (!run)
      timer_count_value <= '0; // RULE7
    else if (match_period)
      timer_count_value <= '0; // RULE1
    else if (step)
      timer_count_value <= timer_count_value + 1'b1; // RULE10
  end

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    match_period |=> timer_count_value == '0;
  endproperty
  a_clear: assert property (p_clear) // RULE1
    else $error("counter did not clear on period match");
  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    (step && !match_period) |=> timer_count_value == $past(timer_count_value) + 1'b1;
  endproperty
  a_step: assert property (p_step) // RULE10
    else $error("counter did not advance on a tick");
  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    (run && !tick) |=> $stable(timer_count_value);
  endproperty
  a_hold: assert property (p_hold) // RULE10
    else $error("counter moved without a tick");
endmodule
`default_nettype wire

// file: core/est_timer.sv
// excitation signal timer top: axi4-lite registers, counter and toggle outputs
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: counter clears on period compare match, giving a 100 us cycle.
// RULE2: compare events A at 50 us, B at 83.33 us, C at 66.67 us.
// RULE3: both outputs start at 0 and toggle on their compare match.
// RULE4: channel C match raises the interrupt each cycle; priority level 11.
// RULE5: excitation waveform starts at half the count cycle.
// RULE6: outputs toggle each cycle, giving 5 kHz over two 100 us cycles.
// RULE7: saw variant counts up from 0 and wraps after cycle value 11999.
// RULE8: saw variant output A toggles at 5999, is 0 at start and stop.
// RULE9: cycle and compare values act directly, no buffer registers.
// RULE10: counter advances per enabled count tick, holds between ticks, clears to 0 while stopped.
module est_timer
  import est_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic excite_out_a,
  output logic excite_out_b,
  output logic irq,
  output logic [3:0] irq_priority
);
  import est_pkg::*;

  logic run;
  logic variant;
  logic [EST_CTRL_PRESC_W-1:0] presc;
  logic [15:0] period_compare_reg;
  logic [15:0] compare_reg_a;
  logic [15:0] compare_reg_b;
  logic [15:0] compare_reg_c;
  logic [15:0] timer_count_value;
  logic [EST_ST_W-1:0] status;
  logic [EST_ST_W-1:0] mask;
  logic [EST_CTRL_PRESC_W-1:0] div_cnt;
  logic tick;
  logic match_a;
  logic match_b;
  logic match_c;
  logic match_period;
  logic [EST_ST_W-1:0] events;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // a function result cannot be sliced, so the word merge is narrowed here
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = merge({16'h0, old}, nw, be);
    return r[15:0];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= EST_OUT_OFS);
  endfunction

  // write channel: address and data taken in either order, one write at a time
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_ok = mapped(aw_addr) && aw_addr != EST_COUNT_OFS && aw_addr != EST_OUT_OFS;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= EST_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? EST_RESP_OKAY : EST_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // register writes; period and compares feed the counter with no shadow copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run <= 1'b0;
      variant <= 1'b0;
      presc <= EST_PRESC_RST;
      period_compare_reg <= EST_PERIOD_RST; // RULE1
      compare_reg_a <= EST_CMP_A_RST; // RULE2
      compare_reg_b <= EST_CMP_B_RST;
      compare_reg_c <= EST_CMP_C_RST;
      mask <= 4'h4; // RULE4
    end
    else if (do_write && wr_ok)
    begin
      unique case (aw_addr)
        EST_CTRL_OFS:
        begin
          if (w_strb[0])
          begin
            run <= w_data[EST_CTRL_RUN_BIT];
            variant <= w_data[EST_CTRL_VARIANT_BIT];
          end
          if (w_strb[1])
            presc <= w_data[EST_CTRL_PRESC_LSB +: EST_CTRL_PRESC_W];
          if (w_strb[0] && w_data[EST_CTRL_VARIANT_BIT] != variant)
          begin
            // switching variant loads the matching default set of values
            period_compare_reg <= w_data[EST_CTRL_VARIANT_BIT] ? EST_PWM_CYCLE : EST_PERIOD_RST; // RULE7
            compare_reg_a <= w_data[EST_CTRL_VARIANT_BIT] ? EST_PWM_CMP_A : EST_CMP_A_RST; // RULE8
            compare_reg_b <= w_data[EST_CTRL_VARIANT_BIT] ? EST_PWM_CMP_B : EST_CMP_B_RST;
          end
        end
        EST_PERIOD_OFS: period_compare_reg <= merge16(period_compare_reg, w_data, w_strb); // RULE9
        EST_CMP_A_OFS: compare_reg_a <= merge16(compare_reg_a, w_data, w_strb);
        EST_CMP_B_OFS: compare_reg_b <= merge16(compare_reg_b, w_data, w_strb);
        EST_CMP_C_OFS: compare_reg_c <= merge16(compare_reg_c, w_data, w_strb);
        EST_MASK_OFS: mask <= w_strb[0] ? w_data[EST_ST_W-1:0] : mask;
        default: ;
      endcase
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= EST_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? EST_RESP_OKAY : EST_RESP_SLVERR;
      unique case (s_axi_araddr)
        EST_CTRL_OFS: s_axi_rdata <= {16'h0, presc, 6'h0, variant, run};
        EST_PERIOD_OFS: s_axi_rdata <= {16'h0, period_compare_reg};
        EST_CMP_A_OFS: s_axi_rdata <= {16'h0, compare_reg_a};
        EST_CMP_B_OFS: s_axi_rdata <= {16'h0, compare_reg_b};
        EST_CMP_C_OFS: s_axi_rdata <= {16'h0, compare_reg_c};
        EST_COUNT_OFS: s_axi_rdata <= {16'h0, timer_count_value};
        EST_STAT_OFS: s_axi_rdata <= {28'h0, status};
        EST_MASK_OFS: s_axi_rdata <= {28'h0, mask};
        EST_OUT_OFS: s_axi_rdata <= {30'h0, excite_out_b, excite_out_a};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // count clock enable; presc 0 counts every aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run || tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end
  assign tick = (div_cnt == presc);

  est_counter #(.CNT_W(16)) u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .run(run),
    .period_compare_reg(period_compare_reg),
    .compare_reg_a(compare_reg_a),
    .compare_reg_b(compare_reg_b),
    .compare_reg_c(compare_reg_c),
    .timer_count_value(timer_count_value),
    .match_a(match_a),
    .match_b(match_b),
    .match_c(match_c),
    .match_period(match_period)
  );

  // outputs low while stopped; first toggle of A lands at half cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      excite_out_a <= 1'b0; // RULE3 RULE8
      excite_out_b <= 1'b0;
    end
    else
    begin
      if (match_a)
        excite_out_a <= !excite_out_a; // RULE3 RULE5 RULE6
      if (match_b)
        excite_out_b <= !excite_out_b; // RULE3 RULE6
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  assign events = {match_period, match_c, match_b, match_a};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= '0;
    else if (do_write && aw_addr == EST_STAT_OFS && w_strb[0])
      status <= (status & ~w_data[EST_ST_W-1:0]) | events;
    else
      status <= status | events; // RULE4
  end
  assign irq = |(status & mask); // RULE4
  assign irq_priority = EST_IRQ_PRIORITY;

  property p_toggle_a;
    @(posedge aclk) disable iff (!aresetn)
    (match_a && run) |=> excite_out_a != $past(excite_out_a);
  endproperty
  a_toggle_a: assert property (p_toggle_a) // RULE3
    else $error("output a did not toggle on match");
  property p_toggle_b;
    @(posedge aclk) disable iff (!aresetn)
    (match_b && run) |=> excite_out_b != $past(excite_out_b);
  endproperty
  a_toggle_b: assert property (p_toggle_b) // RULE3
    else $error("output b did not toggle on match");
  property p_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (run && !match_a) |=> excite_out_a == $past(excite_out_a);
  endproperty
  a_quiet: assert property (p_quiet) // RULE6
    else $error("output a moved without a match");
  property p_stop_low;
    @(posedge aclk) disable iff (!aresetn)
    !run |=> !excite_out_a && !excite_out_b;
  endproperty
  a_stop_low: assert property (p_stop_low) // RULE8
    else $error("outputs not low while stopped");
  property p_irq_c;
    @(posedge aclk) disable iff (!aresetn)
    (match_c && mask[EST_ST_CMP_C]) |=> irq && status[EST_ST_CMP_C];
  endproperty
  a_irq_c: assert property (p_irq_c) // RULE4
    else $error("channel c match raised no interrupt");
  property p_direct;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_ok && aw_addr == EST_PERIOD_OFS && w_strb == 4'hF) |=> period_compare_reg == $past(w_data[15:0]);
  endproperty
  a_direct: assert property (p_direct) // RULE9
    else $error("period write not applied directly");
  property p_bound;
    @(posedge aclk) disable iff (!aresetn)
    (run && $stable(period_compare_reg) && timer_count_value <= period_compare_reg)
      |=> timer_count_value <= period_compare_reg;
  endproperty
  a_bound: assert property (p_bound) // RULE7
    else $error("counter passed the cycle value");
  property p_half;
    @(posedge aclk) disable iff (!aresetn)
    (run && !variant && tick && timer_count_value == EST_CMP_A_RST && compare_reg_a == EST_CMP_A_RST)
      |-> match_a;
  endproperty
  a_half: assert property (p_half) // RULE5
    else $error("no half cycle start event");
  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing");

  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) match_period);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_two: cover property (@(posedge aclk) disable iff (!aresetn) $rose(excite_out_a) ##[1:1000] $fell(excite_out_a));
endmodule
`default_nettype wire

// file: sim/est_rdc_model.sv
// receiving side model: counts and timestamps every excitation edge
`timescale 1ns/1ps
`default_nettype none
module est_rdc_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic excite_a,
  input wire logic excite_b,
  output var int n_a,
  output var int n_b,
  output var int t_a,
  output var int t_a_prev,
  output var int t_b
);
  int cyc = 0;
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  // a pure listener: the excitation input never drives back into the timer
  always_ff @(posedge aclk)
  begin
    cyc <= cyc + 1;
    last_a <= excite_a;
    last_b <= excite_b;
    if (!aresetn)
    begin
      n_a <= 0;
      n_b <= 0;
    end
    else
    begin
      if (excite_a !== last_a)
      begin
        n_a <= n_a + 1;
        t_a_prev <= t_a;
        t_a <= cyc;
      end
      if (excite_b !== last_b)
      begin
        n_b <= n_b + 1;
        t_b <= cyc;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/test_est_timer.sv
// self-checking bench for the excitation signal timer
`timescale 1ns/1ps
`default_nettype none
module test_est_timer;
  import est_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ex_a, ex_b, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d, p, pr;
  logic [1:0] r;
  logic [3:0] prio;
  int n_a, n_b, t_a, t_a_prev, t_b;
  int failures = 0;
  int checked = 0;
  int seed = 32'hdf28e58f;

  est_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .excite_out_a(ex_a),
    .excite_out_b(ex_b), .irq(irq), .irq_priority(prio));
  est_rdc_model rdc (.aclk(aclk), .aresetn(aresetn), .excite_a(ex_a), .excite_b(ex_b), .n_a(n_a),
    .n_b(n_b), .t_a(t_a), .t_a_prev(t_a_prev), .t_b(t_b));

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] cnt_for(input int ns);
    return 32'(ns * EST_CLK_MHZ / 1000);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // the leading edge keeps a strobe from being dropped and raised in one time step
  // no wait limit here: a hung slave is caught by the watchdog
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wok(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] resp;
    wr(a, v, resp);
    chk_resp(resp, EST_RESP_OKAY);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] resp;
    rd(a, v, resp);
    chk_resp(resp, EST_RESP_OKAY);
    chk(v, exp);
  endtask

  task automatic wait_n(input int sel, input int target);
    int n;
    n = 0;
    while ((sel ? n_b : n_a) < target && n < 40000)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  // only whole intervals between two fresh edges are judged, start-up phase is ignored
  task automatic measure(input logic [31:0] exp);
    wait_n(0, n_a + 2);
    chk(32'(t_a - t_a_prev), exp);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge aclk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk({28'h0, prio}, 32'hB);
    chk({30'h0, ex_a, ex_b}, 32'h0);
    rchk(EST_CTRL_OFS, 32'h0);
    rchk(EST_PERIOD_OFS, cnt_for(EST_CYCLE_NS) - 1);
    rchk(EST_CMP_A_OFS, cnt_for(EST_CMP_A_NS));
    rchk(EST_CMP_B_OFS, cnt_for(EST_CMP_B_NS));
    rchk(EST_CMP_C_OFS, cnt_for(EST_CMP_C_NS));
    rchk(EST_MASK_OFS, 32'h4);
    rchk(EST_STAT_OFS, 32'h0);
    rd(8'h40, d, r);
    chk_resp(r, EST_RESP_SLVERR);
    chk(d, 32'h0);
    wr(EST_COUNT_OFS, 32'h1234, r);
    chk_resp(r, EST_RESP_SLVERR);
    done("reset and map");
    wok(EST_CTRL_OFS, 32'h1);
    measure(cnt_for(EST_CYCLE_NS));
    wait_n(1, n_b + 1);
    chk(32'(t_b - t_a), cnt_for(EST_CMP_B_NS) - cnt_for(EST_CMP_A_NS));
    wait_n(0, n_a + 1);
    chk({31'h0, ex_a}, 32'h1);
    wok(EST_CTRL_OFS, 32'h0);
    // outputs clear one edge after run drops
    @(posedge aclk);
    chk({30'h0, ex_a, ex_b}, 32'h0);
    rchk(EST_COUNT_OFS, 32'h0);
    done("excitation run");
    rchk(EST_STAT_OFS, 32'hF);
    chk({31'h0, irq}, 32'h1);
    wok(EST_STAT_OFS, 32'h4);
    rchk(EST_STAT_OFS, 32'hB);
    chk({31'h0, irq}, 32'h0);
    wok(EST_MASK_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wok(EST_MASK_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    done("interrupt");
    for (int k = 0; k < 3; k++)
    begin
      p = 32'(40 + ($random(seed) & 63));
      pr = (k == 0) ? 32'h0 : 32'($random(seed) & 3);
      wok(EST_PERIOD_OFS, p);
      wok(EST_CMP_A_OFS, p >> 1);
      wok(EST_CTRL_OFS, (pr << 8) | 32'h1);
      measure((p + 1) * (pr + 1));
      wok(EST_CTRL_OFS, 32'h0);
    end
    done("random periods");
    wok(EST_CTRL_OFS, 32'h2);
    rchk(EST_PERIOD_OFS, 32'd11999);
    rchk(EST_CMP_A_OFS, 32'd5999);
    wok(EST_CTRL_OFS, 32'h3);
    measure(32'd12000);
    wok(EST_CTRL_OFS, 32'h0);
    @(posedge aclk);
    chk({31'h0, ex_a}, 32'h0);
    done("saw variant");
    report_and_stop();
  end
endmodule
`default_nettype wire
